// ===== verilog/dgr_pkg.sv
// Purpose: constants for the global register bank of the deserializer hub
// Assumes: 8-bit register addresses and data, one core clock
// Notes:   offsets and field positions of the four global registers
package dgr_pkg;
    localparam logic [7:0] OFS_OWN_ADDR     = 8'h00;
    localparam logic [7:0] OFS_SOFT_RESET   = 8'h01;
    localparam logic [7:0] OFS_GLOBAL_CFG   = 8'h02;
    localparam logic [7:0] OFS_DEVICE_STS   = 8'h04;
    localparam logic [7:0] OFS_SHARED_LAST  = 8'h31;
    localparam logic [7:0] OFS_CAM_FIRST    = 8'h32;
    localparam logic [7:0] OFS_CAM_LAST     = 8'h3A;
    localparam logic [7:0] OFS_PORT_SEL     = 8'h4C;
    localparam logic [7:0] OFS_PAGE_LAST    = 8'h7F;
    localparam logic [7:0] OFS_IND_FIRST    = 8'hB0;
    localparam logic [7:0] OFS_IND_LAST     = 8'hB2;
    localparam logic [7:0] OFS_TEST_FIRST   = 8'hD0;
    localparam logic [7:0] OFS_TEST_LAST    = 8'hDF;
    localparam logic [7:0] OFS_RXID_FIRST   = 8'hF0;
    localparam logic [7:0] OFS_RXID_LAST    = 8'hF5;
    localparam logic [7:0] OFS_PADDR_FIRST  = 8'hF8;
    localparam logic [7:0] OFS_PADDR_LAST   = 8'hFB;
    localparam logic [6:0] OWN_ADDR_DEFAULT = 7'h3D;
    localparam int         BIT_OVERRIDE     = 0;
    localparam int         BIT_RST_KEEP     = 0;
    localparam int         BIT_RST_FULL     = 1;
    localparam int         BIT_RELOAD       = 2;
    localparam int         BIT_REFCLK_FORCE = 0;
    localparam int         BIT_PARITY_EN    = 1;
    localparam int         BIT_SLEEP_SEL    = 2;
    localparam int         BIT_OUT_EN       = 3;
    localparam int         BIT_OUT_EN_MODE  = 4;
    localparam int         BIT_PROXY_EN     = 5;
    localparam int         BIT_INIT_DONE    = 6;
    localparam logic [7:0] CFG_DEFAULT      = 8'h1E;
    localparam logic [1:0] PORT_WR_DEFAULT  = 2'h3;
    localparam logic [3:0] RELOAD_CYCLES    = 4'h4;
    // camera lane drive modes
    typedef enum logic [1:0] {
        DGR_LANE_RUN  = 2'b00,
        DGR_LANE_LP11 = 2'b01,
        DGR_LANE_HS0  = 2'b10,
        DGR_LANE_HIZ  = 2'b11
    } dgr_lane_t;
    typedef enum logic [1:0] {
        DGR_IDLE   = 2'b00,
        DGR_RELOAD = 2'b01,
        DGR_RESET  = 2'b10
    } dgr_phase_t;
endpackage

// ===== verilog/dgr_register_bank.sv
// Purpose: global register bank with address decode and paged port window
// Assumes: one register access per cycle from the local target or the side channel
// Notes:   per-port window storage lives outside; this bank decodes it and steers it
//
// What this block does
// - read-to-clear fields clear after being read
// - self-clearing bits act then return zero
// - latched status holds until read
// - strap fields load from sampled pins
// - both access paths reach all blocks
// - decode shared and camera ranges, reserve gap
// - paged port window, read select, broadcast write
// - decode indirect, test, ID, addressing ranges
// - address field reports address in use
// - override bit unlocks address field writes
// - reload bit restores defaults and straps
// - full reset clears logic and configuration
// - logic reset keeps configuration contents
// - proxy bit gates remote local-bus mastering
// - unlocked output mode: high-impedance, LP-11 or HS-0
// - sleep select with enable low gives high-impedance
// - unlocked with output mode set and sleep select low gives HS-0
// - parity checker enable bit
// - force reference clock present indication
// - init-done status bit after default loading
`timescale 1ns/1ps
`default_nettype none
module dgr_register_bank (
    input  wire logic            core_clk,
    input  wire logic            rstn,
    input  wire logic [6:0]      strapAddress,
    input  wire logic            localReq,
    input  wire logic            chanReq,
    input  wire logic            regWrite,
    input  wire logic [7:0]      regAddr,
    input  wire logic [7:0]      regWdata,
    input  wire logic            anyPortLocked,
    input  wire logic            refclkDetected,
    input  wire logic            latchedLowIn,
    input  wire logic            latchedHighIn,
    input  wire logic            clearOnReadIn,
    output logic [7:0]           regRdata,
    output logic                 regAck,
    output logic [6:0]           ownTargetAddress,
    output logic [1:0]           portReadSelect,
    output logic [1:0]           portWriteEnable,
    output logic                 windowHit,
    output logic                 extHit,
    output logic                 logicResetPulse,
    output logic                 configResetPulse,
    output logic                 proxyMasterEnable,
    output logic                 parityCheckEnable,
    output logic                 refclkPresent,
    output dgr_pkg::dgr_lane_t   laneMode
);
    import dgr_pkg::*;

    typedef struct packed {
        logic [6:0]  addr;
        logic        override;
        logic [6:0]  strap;
        logic [4:0]  rstSpare;
        logic [7:0]  cfg;
        logic [1:0]  rdSel;
        logic [1:0]  wrEn;
        logic        initDone;
        logic        llHold;
        logic        lhHold;
        logic        rcFlag;
        logic [3:0]  count;
        dgr_phase_t  phase;
        logic        started;
        logic [7:0]  rdata;
        logic        ack;
        logic        winHit;
        logic        xHit;
        logic        logicRst;
        logic        cfgRst;
        logic        refclk;
        dgr_lane_t   lane;
    } dgr_state_t;

    dgr_state_t st;
    dgr_state_t next_st;
    logic       access;
    logic       wrOwn;
    logic       rdSts;
    logic       inWindow;
    logic       inExt;
    logic       inReserved;

    always_comb begin
        access     = localReq | chanReq;
        inWindow   = regAddr >= OFS_PORT_SEL && regAddr <= OFS_PAGE_LAST;
        inExt      = (regAddr >= OFS_CAM_FIRST && regAddr <= OFS_CAM_LAST)
                   || (regAddr >= OFS_IND_FIRST && regAddr <= OFS_IND_LAST)
                   || (regAddr >= OFS_TEST_FIRST && regAddr <= OFS_TEST_LAST)
                   || (regAddr >= OFS_RXID_FIRST && regAddr <= OFS_RXID_LAST)
                   || (regAddr >= OFS_PADDR_FIRST && regAddr <= OFS_PADDR_LAST)
                   || (regAddr > OFS_DEVICE_STS && regAddr <= OFS_SHARED_LAST);
        inReserved = !inWindow && !inExt && regAddr > OFS_DEVICE_STS;
        wrOwn      = access && regWrite && !inReserved;
        rdSts      = access && !regWrite && regAddr == OFS_DEVICE_STS;

        next_st          = st;
        next_st.ack      = access;
        next_st.logicRst = 1'b0;
        next_st.cfgRst   = 1'b0;
        next_st.winHit   = access && inWindow && regAddr != OFS_PORT_SEL;
        next_st.xHit     = access && inExt;
        next_st.rdata    = 8'h00;

        if (!st.started) begin
            next_st.started = 1'b1;
            next_st.strap   = strapAddress;
        end

        if (!latchedLowIn)
            next_st.llHold = 1'b1;
        if (latchedHighIn)
            next_st.lhHold = 1'b1;
        if (clearOnReadIn)
            next_st.rcFlag = 1'b1;

        if (access && !regWrite) begin
            case (regAddr)
                OFS_OWN_ADDR:   next_st.rdata = {st.addr, st.override};
                OFS_SOFT_RESET: next_st.rdata = {st.rstSpare, 3'b000};
                OFS_GLOBAL_CFG: next_st.rdata = st.cfg;
                OFS_DEVICE_STS: next_st.rdata = {st.rcFlag, st.initDone, 2'b00,
                                                 st.lhHold, st.llHold ? 1'b0 : latchedLowIn, 2'b00};
                OFS_PORT_SEL:   next_st.rdata = {2'b00, st.rdSel, 2'b00, st.wrEn};
                default:        next_st.rdata = 8'h00;
            endcase
        end

        // clear after read, new event wins
        if (rdSts) begin
            next_st.llHold = !latchedLowIn;
            next_st.lhHold = latchedHighIn;
            next_st.rcFlag = clearOnReadIn;
        end

        if (wrOwn) begin
            case (regAddr)
                OFS_OWN_ADDR: begin
                    next_st.override = regWdata[BIT_OVERRIDE];
                    if (regWdata[BIT_OVERRIDE])
                        next_st.addr = regWdata[7:1];
                    else
                        next_st.addr = st.strap;
                end
                OFS_SOFT_RESET: begin
                    next_st.rstSpare = regWdata[7:3];
                    if (regWdata[BIT_RST_FULL] || regWdata[BIT_RELOAD]) begin
                        next_st.phase    = regWdata[BIT_RST_FULL] ? DGR_RESET : DGR_RELOAD;
                        next_st.count    = RELOAD_CYCLES;
                        next_st.initDone = 1'b0;
                    end
                    if (regWdata[BIT_RST_KEEP])
                        next_st.logicRst = 1'b1;
                end
                OFS_GLOBAL_CFG: next_st.cfg = regWdata;
                OFS_PORT_SEL: begin
                    next_st.rdSel = regWdata[5:4];
                    next_st.wrEn  = regWdata[1:0];
                end
                default: ;
            endcase
        end

        case (st.phase)
            DGR_IDLE: ;
            DGR_RELOAD, DGR_RESET: begin
                next_st.count = st.count - 4'h1;
                if (st.count == 4'h1) begin
                    next_st.addr     = strapAddress;
                    next_st.strap    = strapAddress;
                    next_st.override = 1'b0;
                    next_st.rstSpare = 5'h00;
                    next_st.cfg      = CFG_DEFAULT;
                    next_st.rdSel    = 2'b00;
                    next_st.wrEn     = PORT_WR_DEFAULT;
                    next_st.phase    = DGR_IDLE;
                    next_st.initDone = 1'b1;
                    next_st.logicRst = st.phase == DGR_RESET;
                    next_st.cfgRst   = 1'b1;
                end
            end
            default: next_st.phase = DGR_IDLE;
        endcase

        next_st.refclk = next_st.cfg[BIT_REFCLK_FORCE] | refclkDetected;
        if (!anyPortLocked && !next_st.cfg[BIT_OUT_EN_MODE])
            next_st.lane = DGR_LANE_HIZ;
        else if (next_st.cfg[BIT_SLEEP_SEL] && !next_st.cfg[BIT_OUT_EN])
            next_st.lane = DGR_LANE_HIZ;
        else if (!anyPortLocked && !next_st.cfg[BIT_SLEEP_SEL])
            next_st.lane = DGR_LANE_HS0;
        else if (!anyPortLocked)
            next_st.lane = DGR_LANE_LP11;
        else
            next_st.lane = DGR_LANE_RUN;
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            st          <= '0;
            st.addr     <= OWN_ADDR_DEFAULT;
            st.strap    <= OWN_ADDR_DEFAULT;
            st.cfg      <= CFG_DEFAULT;
            st.wrEn     <= PORT_WR_DEFAULT;
            st.phase    <= DGR_RELOAD;
            st.count    <= RELOAD_CYCLES;
            st.lane     <= DGR_LANE_HIZ;
        end else begin
            st <= next_st;
        end
    end

    assign ownTargetAddress  = st.addr;
    assign regRdata          = st.rdata;
    assign regAck            = st.ack;
    assign portReadSelect    = st.rdSel;
    assign portWriteEnable   = st.wrEn;
    assign windowHit         = st.winHit;
    assign extHit            = st.xHit;
    assign logicResetPulse   = st.logicRst;
    assign configResetPulse  = st.cfgRst;
    assign proxyMasterEnable = st.cfg[BIT_PROXY_EN];
    assign parityCheckEnable = st.cfg[BIT_PARITY_EN];
    assign refclkPresent     = st.refclk;
    assign laneMode          = st.lane;

    property p_reload_done;
        @(posedge core_clk) disable iff (!rstn)
        (st.phase == DGR_RELOAD && st.count == 4'h1) |=> (st.initDone && st.cfg == CFG_DEFAULT);
    endproperty
    a_reload_done: assert property (p_reload_done) else $error("reload did not restore defaults");

    property p_full_reset;
        @(posedge core_clk) disable iff (!rstn)
        (wrOwn && regAddr == OFS_SOFT_RESET && regWdata[BIT_RST_FULL]) |-> ##5 configResetPulse && logicResetPulse;
    endproperty
    a_full_reset: assert property (p_full_reset) else $error("full reset did not complete");

    property p_keep_reset;
        @(posedge core_clk) disable iff (!rstn)
        (wrOwn && regAddr == OFS_SOFT_RESET && regWdata[BIT_RST_KEEP] && !regWdata[BIT_RST_FULL]
         && !regWdata[BIT_RELOAD] && st.phase == DGR_IDLE) |=> logicResetPulse && $stable(st.cfg);
    endproperty
    a_keep_reset: assert property (p_keep_reset) else $error("logic reset lost configuration");

    property p_self_clear;
        @(posedge core_clk) disable iff (!rstn)
        logicResetPulse |=> !logicResetPulse || $past(st.phase) != DGR_IDLE || $past(wrOwn);
    endproperty
    a_self_clear: assert property (p_self_clear) else $error("reset request stuck high");

    property p_reserved;
        @(posedge core_clk) disable iff (!rstn)
        (access && inReserved) |=> regRdata == 8'h00 && $stable(st.cfg) && $stable(st.addr);
    endproperty
    a_reserved: assert property (p_reserved) else $error("reserved access had an effect");

    property p_addr_locked;
        @(posedge core_clk) disable iff (!rstn)
        (wrOwn && regAddr == OFS_OWN_ADDR && !regWdata[BIT_OVERRIDE] && st.phase == DGR_IDLE)
            |=> ownTargetAddress == st.strap;
    endproperty
    a_addr_locked: assert property (p_addr_locked) else $error("address changed without override");

    property p_read_clear;
        @(posedge core_clk) disable iff (!rstn)
        (rdSts && st.rcFlag && !clearOnReadIn) |=> regRdata[7] && !st.rcFlag;
    endproperty
    a_read_clear: assert property (p_read_clear) else $error("read-to-clear did not clear");

    property p_hs0;
        @(posedge core_clk) disable iff (!rstn)
        (!anyPortLocked && st.cfg[BIT_OUT_EN_MODE] && !st.cfg[BIT_SLEEP_SEL] && $stable(st.cfg)
         && !$past(anyPortLocked)) |-> laneMode == DGR_LANE_HS0;
    endproperty
    a_hs0: assert property (p_hs0) else $error("lanes not in HS-0 while unlocked");

    property p_refclk;
        @(posedge core_clk) disable iff (!rstn)
        $past(st.cfg[BIT_REFCLK_FORCE]) && st.cfg[BIT_REFCLK_FORCE] |-> refclkPresent;
    endproperty
    a_refclk: assert property (p_refclk) else $error("reference clock not forced present");
endmodule
`default_nettype wire

// ===== tb/dgr_host_model.sv
// Purpose: host controller model issuing register accesses
// Assumes: one access per call, request is a single-cycle pulse
// Notes:   released address and data show the inverse of the last value
`timescale 1ns/1ps
`default_nettype none
module dgr_host_model (
    input  wire logic       core_clk,
    output logic            localReq,
    output logic            chanReq,
    output logic            regWrite,
    output logic [7:0]      regAddr,
    output logic [7:0]      regWdata
);
    initial begin
        localReq = 1'b0;
        chanReq = 1'b0;
        regWrite = 1'b0;
        regAddr = 8'hFF;
        regWdata = 8'h00;
    end
    task automatic access(input logic wr, input logic [7:0] addr, input logic [7:0] data, input logic viaChan);
        @(negedge core_clk);
        localReq = ~viaChan;
        chanReq = viaChan;
        regWrite = wr;
        regAddr = addr;
        regWdata = data;
        @(negedge core_clk);
        localReq = 1'b0;
        chanReq = 1'b0;
        regWrite = ~wr;
        regAddr = ~addr;
        regWdata = ~data;
    endtask
endmodule
`default_nettype wire

// ===== tb/testbench.sv
// Purpose: self-checking bench for the global register bank
// Assumes: host model issues accesses, inputs change at the falling edge
// Notes:   read results are compared in order of the acknowledges
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import dgr_pkg::*;
    logic       core_clk = 1'b0, rstn = 1'b0, anyPortLocked = 1'b0, refclkDetected = 1'b0;
    logic       latchedLowIn = 1'b1, latchedHighIn = 1'b0, clearOnReadIn = 1'b0;
    logic [6:0] strap = 7'h00, ownTargetAddress;
    logic       localReq, chanReq, regWrite, regAck, windowHit, extHit, logicResetPulse, configResetPulse;
    logic       proxyMasterEnable, parityCheckEnable, refclkPresent;
    logic [7:0] regAddr, regWdata, regRdata, v;
    logic [1:0] portReadSelect, portWriteEnable;
    dgr_lane_t  laneMode;
    int         numErrors = 0, nTests = 0, cycles = 0;
    logic [15:0] expQ[$];
    logic [7:0] cf[5] = '{8'h14, 8'h1C, 8'h0C, 8'h18, 8'h1C};
    logic       lk[5] = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b1};
    dgr_lane_t  lm[5] = '{DGR_LANE_HIZ, DGR_LANE_LP11, DGR_LANE_HIZ, DGR_LANE_HS0, DGR_LANE_RUN};
    logic [7:0] rsv[8] = '{8'h03, 8'h3B, 8'h4B, 8'h80, 8'hC5, 8'hE0, 8'hF6, 8'hFF};

    always #5 core_clk = ~core_clk;

    dgr_host_model host (.core_clk(core_clk), .localReq(localReq), .chanReq(chanReq), .regWrite(regWrite),
        .regAddr(regAddr), .regWdata(regWdata));
    dgr_register_bank DUT (.core_clk(core_clk), .rstn(rstn), .strapAddress(strap), .localReq(localReq),
        .chanReq(chanReq), .regWrite(regWrite), .regAddr(regAddr), .regWdata(regWdata),
        .anyPortLocked(anyPortLocked), .refclkDetected(refclkDetected), .latchedLowIn(latchedLowIn),
        .latchedHighIn(latchedHighIn), .clearOnReadIn(clearOnReadIn), .regRdata(regRdata), .regAck(regAck),
        .ownTargetAddress(ownTargetAddress), .portReadSelect(portReadSelect), .portWriteEnable(portWriteEnable),
        .windowHit(windowHit), .extHit(extHit), .logicResetPulse(logicResetPulse),
        .configResetPulse(configResetPulse), .proxyMasterEnable(proxyMasterEnable),
        .parityCheckEnable(parityCheckEnable), .refclkPresent(refclkPresent), .laneMode(laneMode));

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        nTests++;
        if (seen !== exp) begin
            numErrors++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e, input logic [7:0] m);
        expQ.push_back({e, m});
        host.access(1'b0, a, 8'h00, 1'($urandom));
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        expQ.push_back(16'h00FF);
        host.access(1'b1, a, d, 1'($urandom));
    endtask
    task automatic waitReload(input logic withLogic);
        for (int k = 0; k < 12 && configResetPulse !== 1'b1; k++) @(negedge core_clk);
        check({6'h0, configResetPulse, logicResetPulse}, {6'h0, 1'b1, withLogic});
    endtask
    task automatic stopTest();
        $display("errors %0d comparisons %0d", numErrors, nTests);
        if (numErrors == 0 && nTests > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask

    // answers are compared in issue order
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 3000) begin
            numErrors++;
            stopTest();
        end
        if (regAck === 1'b1) begin
            if (expQ.size() == 0) check(regRdata, 8'hEE);
            else begin
                check(regRdata & expQ[0][7:0], expQ[0][15:8]);
                void'(expQ.pop_front());
            end
        end
    end

    initial begin
        v = 8'($urandom(81));
        strap = 7'($urandom);
        repeat (20) @(posedge core_clk);
        @(negedge core_clk);
        check({1'b0, ownTargetAddress}, {1'b0, OWN_ADDR_DEFAULT});
        rstn = 1'b1;
        rd(OFS_DEVICE_STS, 8'h00, 8'h40);
        waitReload(1'b0);
        rd(OFS_DEVICE_STS, 8'h40, 8'h40);
        rd(OFS_OWN_ADDR, {strap, 1'b0}, 8'hFF);
        rd(OFS_GLOBAL_CFG, CFG_DEFAULT, 8'hFF);
        rd(OFS_SOFT_RESET, 8'h00, 8'hFF);
        wr(OFS_OWN_ADDR, {~strap, 1'b1});
        check({1'b0, ownTargetAddress}, {1'b0, ~strap});
        rd(OFS_OWN_ADDR, {~strap, 1'b1}, 8'hFF);
        wr(OFS_OWN_ADDR, {~strap, 1'b0});
        rd(OFS_OWN_ADDR, {strap, 1'b0}, 8'hFF);
        for (int i = 0; i < 4; i++) begin
            v = 8'($urandom);
            refclkDetected = 1'($urandom);
            wr(OFS_GLOBAL_CFG, v);
            check({6'h0, proxyMasterEnable, parityCheckEnable}, {6'h0, v[5], v[1]});
            @(negedge core_clk);
            check({7'h0, refclkPresent}, {7'h0, v[0] | refclkDetected});
            rd(OFS_GLOBAL_CFG, v, 8'hFF);
        end
        for (int i = 0; i < 5; i++) begin
            anyPortLocked = lk[i];
            wr(OFS_GLOBAL_CFG, cf[i]);
            @(negedge core_clk);
            check({6'h0, laneMode}, {6'h0, lm[i]});
        end
        foreach (rsv[i]) begin
            wr(rsv[i], 8'hA5);
            rd(rsv[i], 8'h00, 8'hFF);
        end
        rd(OFS_GLOBAL_CFG, 8'h1C, 8'hFF);
        wr(OFS_PORT_SEL, 8'h12);
        check({4'h0, portReadSelect, portWriteEnable}, 8'h06);
        rd(8'h50, 8'h00, 8'h00);
        check({7'h0, windowHit}, 8'h01);
        rd(8'hD3, 8'h00, 8'h00);
        check({7'h0, extHit}, 8'h01);
        clearOnReadIn = 1'b1;
        latchedHighIn = 1'b1;
        latchedLowIn = 1'b0;
        @(negedge core_clk);
        clearOnReadIn = 1'b0;
        latchedHighIn = 1'b0;
        latchedLowIn = 1'b1;
        rd(OFS_DEVICE_STS, 8'h88, 8'h8C);
        rd(OFS_DEVICE_STS, 8'h04, 8'h8C);
        wr(OFS_GLOBAL_CFG, 8'h2B);
        wr(OFS_OWN_ADDR, {~strap, 1'b1});
        wr(OFS_SOFT_RESET, 8'hF9);
        check({7'h0, logicResetPulse}, 8'h01);
        rd(OFS_SOFT_RESET, 8'hF8, 8'hFF);
        rd(OFS_GLOBAL_CFG, 8'h2B, 8'hFF);
        wr(OFS_SOFT_RESET, 8'h04);
        waitReload(1'b0);
        rd(OFS_GLOBAL_CFG, CFG_DEFAULT, 8'hFF);
        rd(OFS_OWN_ADDR, {strap, 1'b0}, 8'hFF);
        wr(OFS_GLOBAL_CFG, 8'h2B);
        wr(OFS_SOFT_RESET, 8'h02);
        waitReload(1'b1);
        rd(OFS_GLOBAL_CFG, CFG_DEFAULT, 8'hFF);
        rd(OFS_DEVICE_STS, 8'h40, 8'h40);
        repeat (3) @(negedge core_clk);
        check(8'(expQ.size()), 8'h00);
        stopTest();
    end
endmodule
`default_nettype wire
